//--- pkg/qdac_pkg.sv
// Shared constants and types for the quad DAC serial command logic
package qdac_pkg;
	localparam int WORD_W = 16;
	localparam int CODE_W = 12;
	localparam int NUM_CH = 4;
	localparam int CNT_W = 16;
	localparam int SEL_HI_POS = 15;
	localparam int SEL_LO_POS = 14;
	localparam int CTL_HI_POS = 13;
	localparam int CTL_LO_POS = 12;
	localparam int SYNC_STAGES = 2;
	localparam logic [CNT_W-1:0] FRAME_MIN_EDGES = 16'h0010;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
	localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
	localparam logic [1:0] CTL_ALL_OR_NOP = 2'h0;
	localparam logic [1:0] CTL_LOAD_IN = 2'h1;
	localparam logic [1:0] CTL_UPDATE = 2'h2;
	localparam logic [1:0] CTL_LOAD_UPD = 2'h3;
	localparam logic [1:0] SEL_MODE_RISE = 2'h3;
	localparam logic [1:0] SEL_MODE_FALL = 2'h2;
	typedef enum logic {
		QDAC_ECHO_FALL = 1'b0,
		QDAC_ECHO_RISE = 1'b1
	} qdac_echo_e;
	localparam qdac_echo_e ECHO_RESET = QDAC_ECHO_RISE;
	typedef logic [CODE_W-1:0] qdac_code_t;
	typedef logic [NUM_CH-1:0][CODE_W-1:0] qdac_bank_t;
	typedef logic [WORD_W-1:0] qdac_word_t;
	typedef logic [CNT_W-1:0] qdac_cnt_t;
endpackage : qdac_pkg

//--- pkg/qdac_link_if.sv
// Link between the serial-clock shifter and the command decoder
`timescale 1ns/1ns
interface qdac_link_if;
	import qdac_pkg::*;
	qdac_word_t word;
	qdac_cnt_t edge_cnt;
	qdac_echo_e echo_mode;
	modport shifter (output word, output edge_cnt, input echo_mode);
	modport decoder (input word, input edge_cnt, output echo_mode);
endinterface : qdac_link_if

//--- core/qdac_serial_shifter.sv
// Serial-clock domain: shift register, edge counter and echo output
`timescale 1ns/1ns
module qdac_serial_shifter (
	input wire logic serial_clk,
	input wire logic rst_n,
	input wire logic chip_select_n,
	input wire logic serial_data_in,
	output logic serial_echo_out,
	qdac_link_if.shifter link
);
	import qdac_pkg::*;

	qdac_word_t sr_reg, sr_next;
	qdac_cnt_t cnt_reg, cnt_next;
	logic rise_reg, rise_next;
	logic fall_reg, fall_next;
	logic mode_s1_reg, mode_s2_reg;

	// Nothing moves while chip select is high
	always_comb begin
		sr_next = sr_reg;
		cnt_next = cnt_reg;
		rise_next = rise_reg;
		if (!chip_select_n) begin
			sr_next = {sr_reg[WORD_W-2:0], serial_data_in};
			cnt_next = CNT_W'(cnt_reg + 1'b1);
			rise_next = sr_reg[WORD_W-1];
		end
	end

	always_ff @(posedge serial_clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_reg <= WORD_RESET;
			cnt_reg <= CNT_RESET;
			rise_reg <= 1'b0;
		end else begin
			sr_reg <= sr_next;
			cnt_reg <= cnt_next;
			rise_reg <= rise_next;
		end
	end

	// Half a cycle behind the rising stage gives the 16.5 cycle lag
	always_comb begin
		fall_next = chip_select_n ? fall_reg : rise_reg;
	end

	always_ff @(negedge serial_clk or negedge rst_n) begin
		if (!rst_n) begin
			fall_reg <= 1'b0;
		end else begin
			fall_reg <= fall_next;
		end
	end

	// Mode changes only between frames, so two serial clock edges suffice
	always_ff @(posedge serial_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_s1_reg <= ECHO_RESET;
			mode_s2_reg <= ECHO_RESET;
		end else begin
			mode_s1_reg <= link.echo_mode;
			mode_s2_reg <= mode_s1_reg;
		end
	end

	assign serial_echo_out = mode_s2_reg ? rise_reg : fall_reg;
	assign link.word = sr_reg;
	assign link.edge_cnt = cnt_reg;
endmodule : qdac_serial_shifter

//--- core/qdac_command_top.sv
// Quad DAC serial command decoder and input/DAC register banks
`timescale 1ns/1ns
module qdac_command_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic serial_clk,
	input wire logic chip_select_n,
	input wire logic serial_data_in,
	input wire logic dac_latch_strobe_n,
	output logic serial_echo_out,
	output qdac_pkg::qdac_bank_t input_code,
	output qdac_pkg::qdac_bank_t dac_code,
	output qdac_pkg::qdac_echo_e echo_mode
);
	import qdac_pkg::*;

	// Replace one channel of a bank; shared by the two single-channel load commands and the checks
	function automatic qdac_bank_t put_channel(
		input qdac_bank_t bank,
		input logic [1:0] ch,
		input qdac_code_t code
	);
		qdac_bank_t result;
		result = bank;
		result[ch] = code;
		return result;
	endfunction : put_channel

	qdac_link_if link ();

	qdac_serial_shifter u_shifter (
		.serial_clk(serial_clk),
		.rst_n(rst_n),
		.chip_select_n(chip_select_n),
		.serial_data_in(serial_data_in),
		.serial_echo_out(serial_echo_out),
		.link(link.shifter)
	);

	// Pin synchronisers; third chip select stage only feeds the edge detect
	logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
	logic lat_s1_reg, lat_s2_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
			lat_s1_reg <= 1'b1;
			lat_s2_reg <= 1'b1;
		end else begin
			cs_s1_reg <= chip_select_n;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
			lat_s1_reg <= dac_latch_strobe_n;
			lat_s2_reg <= lat_s1_reg;
		end
	end

	logic cs_rise;
	logic latch_hi;
	assign cs_rise = cs_s2_reg && !cs_s3_reg;
	assign latch_hi = lat_s2_reg;

	// Word and counter are quiet while chip select is high, so they are
	// sampled only after the synchronised rise; a host must keep chip
	// select high for at least three reference clocks between frames.
	qdac_word_t word;
	qdac_cnt_t frame_edges;
	qdac_cnt_t cnt_seen_reg, cnt_seen_next;
	logic [1:0] sel;
	logic [1:0] ctl;
	qdac_code_t data;
	logic enough;
	logic upd;

	assign word = link.word;
	assign sel = word[SEL_HI_POS:SEL_LO_POS];
	assign ctl = word[CTL_HI_POS:CTL_LO_POS];
	assign data = word[CODE_W-1:0];
	// Counter wraps; difference stays right below 65536 edges per frame
	assign frame_edges = CNT_W'(link.edge_cnt - cnt_seen_reg);
	assign enough = frame_edges >= FRAME_MIN_EDGES;
	assign upd = cs_rise && enough;

	// Command decode shared by the checks below; the update case decodes alone
	logic cmd_load_all;
	logic cmd_nop;
	logic cmd_load_in;
	logic cmd_load_upd;
	logic cmd_update;

	always_comb begin
		cmd_load_all = 1'b0;
		cmd_nop = 1'b0;
		cmd_load_in = 1'b0;
		cmd_load_upd = 1'b0;
		cmd_update = 1'b0;
		case (ctl)
			CTL_ALL_OR_NOP: begin
				cmd_load_all = !sel[0];
				cmd_nop = sel[0];
			end
			CTL_LOAD_IN: begin
				cmd_load_in = 1'b1;
			end
			CTL_LOAD_UPD: begin
				cmd_load_upd = 1'b1;
			end
			default: begin
				cmd_update = 1'b1;
			end
		endcase
	end

	qdac_bank_t in_reg, in_next;
	qdac_bank_t dac_reg, dac_next;
	qdac_echo_e mode_reg, mode_next;

	always_comb begin
		in_next = in_reg;
		dac_next = dac_reg;
		mode_next = mode_reg;
		cnt_seen_next = cs_rise ? link.edge_cnt : cnt_seen_reg;
		if (upd) begin
			case (ctl)
				CTL_ALL_OR_NOP: begin
					if (!sel[0]) begin
						in_next = {NUM_CH{data}};
						dac_next = {NUM_CH{data}};
					end
					// Else no-operation: word only passes through
				end
				CTL_LOAD_IN: begin
					in_next = put_channel(in_reg, sel, data);
					if (!latch_hi) begin
						dac_next[sel] = data;
					end
				end
				CTL_LOAD_UPD: begin
					in_next = put_channel(in_reg, sel, data);
					if (latch_hi) begin
						dac_next = in_next;
					end else begin
						dac_next[sel] = data;
					end
				end
				default: begin
					// With latch low the copy matches the transparent path
					dac_next = in_reg;
					if (sel == SEL_MODE_RISE) begin
						mode_next = QDAC_ECHO_RISE;
					end else if (sel == SEL_MODE_FALL) begin
						mode_next = QDAC_ECHO_FALL;
					end
				end
			endcase
		end
		if (!latch_hi) begin
			dac_next = in_next;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_reg <= {NUM_CH{CODE_RESET}};
			dac_reg <= {NUM_CH{CODE_RESET}};
			mode_reg <= ECHO_RESET;
			cnt_seen_reg <= CNT_RESET;
		end else begin
			in_reg <= in_next;
			dac_reg <= dac_next;
			mode_reg <= mode_next;
			cnt_seen_reg <= cnt_seen_next;
		end
	end

	assign link.echo_mode = mode_reg;
	assign input_code = in_reg;
	assign dac_code = dac_reg;
	assign echo_mode = mode_reg;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_nop_keeps_regs: assert property (
		upd && ctl == CTL_ALL_OR_NOP && sel[0] |=> $stable(in_reg) && $stable(mode_reg)
	) else $error("nop changed input registers or mode");

	a_short_frame_ignored: assert property (
		cs_rise && !enough |=> $stable(in_reg) && $stable(mode_reg)
	) else $error("short frame changed state");

	a_load_input_only: assert property (
		upd && ctl == CTL_LOAD_IN && latch_hi && lat_s1_reg
		|=> in_reg[$past(sel)] == $past(data) && dac_reg == $past(dac_reg)
	) else $error("input load wrong or DAC disturbed");

	a_load_all_same: assert property (
		upd && ctl == CTL_ALL_OR_NOP && !sel[0]
		|=> in_reg == {NUM_CH{$past(data)}} && dac_reg == {NUM_CH{$past(data)}}
	) else $error("load-all did not fill every register");

	a_load_then_update: assert property (
		upd && ctl == CTL_LOAD_UPD && latch_hi |=> dac_reg == in_reg
	) else $error("load-and-update left DAC differing");

	a_copy_all: assert property (
		upd && ctl == CTL_UPDATE && !sel[1] && latch_hi |=> dac_reg == $past(in_reg) && $stable(in_reg)
	) else $error("update-all did not copy inputs");

	a_mode_rise_cmd: assert property (
		upd && ctl == CTL_UPDATE && sel == SEL_MODE_RISE
		|=> mode_reg == QDAC_ECHO_RISE && dac_reg == $past(in_reg)
	) else $error("mode 1 command failed");

	a_mode_fall_cmd: assert property (
		upd && ctl == CTL_UPDATE && sel == SEL_MODE_FALL
		|=> mode_reg == QDAC_ECHO_FALL && dac_reg == $past(in_reg)
	) else $error("mode 0 command failed");

	a_immediate_update: assert property (
		upd && ctl[0] && !latch_hi |=> dac_reg[$past(sel)] == $past(data) && in_reg[$past(sel)] == $past(data)
	) else $error("immediate channel update missed");

	a_transparent_follow: assert property (
		!latch_hi |=> dac_reg == in_reg
	) else $error("DAC not transparent with latch low");

	a_latched_hold: assert property (
		latch_hi && !upd |=> $stable(dac_reg)
	) else $error("latched DAC registers changed");

	a_mode_only_on_cmd: assert property (
		!upd |=> $stable(mode_reg)
	) else $error("echo mode changed without a command");

	// Input registers move only at an accepted chip select rise
	a_input_only_on_upd: assert property (
		!upd
		|=> $stable(in_reg)
	) else $error("input registers changed outside a command");

	a_cs_rise_pulse: assert property (
		cs_rise
		|=> !cs_rise
	) else $error("chip select rise seen twice");

	a_nop_keeps_dac: assert property (
		upd && cmd_nop && latch_hi
		|=> $stable(dac_reg)
	) else $error("nop changed DAC registers");

	a_load_in_others: assert property (
		upd && cmd_load_in
		|=> in_reg == put_channel($past(in_reg), $past(sel), $past(data))
	) else $error("input load touched other channels");

	a_load_in_latched: assert property (
		upd && cmd_load_in && latch_hi
		|=> $stable(dac_reg)
	) else $error("input load changed latched DAC registers");

	a_load_upd_input: assert property (
		upd && cmd_load_upd
		|=> in_reg == put_channel($past(in_reg), $past(sel), $past(data))
	) else $error("load-and-update input register wrong");

	a_load_upd_latched: assert property (
		upd && cmd_load_upd && latch_hi
		|=> dac_reg == put_channel($past(in_reg), $past(sel), $past(data))
	) else $error("load-and-update DAC registers wrong");

	a_all_ignores_latch: assert property (
		upd && cmd_load_all && !latch_hi
		|=> dac_reg == in_reg
	) else $error("load-all differs with latch low");

	a_update_keeps_in: assert property (
		upd && cmd_update
		|=> $stable(in_reg)
	) else $error("update command changed input registers");

	a_update_hold_mode: assert property (
		upd && cmd_update && !sel[1]
		|=> $stable(mode_reg)
	) else $error("plain update changed echo mode");

	a_update_latch_low: assert property (
		upd && cmd_update && !latch_hi
		|=> dac_reg == in_reg
	) else $error("update with latch low left DAC differing");

	a_update_copies_all: assert property (
		upd && cmd_update && latch_hi
		|=> dac_reg == $past(in_reg)
	) else $error("update did not copy all inputs");

	// Only the two mode commands may move the echo mode
	a_load_keeps_mode: assert property (
		upd && !cmd_update
		|=> $stable(mode_reg)
	) else $error("non-mode command changed echo mode");

	a_immediate_others: assert property (
		upd && ctl[0] && !latch_hi
		|=> in_reg == put_channel($past(in_reg), $past(sel), $past(data))
	) else $error("immediate load touched other inputs");

	a_short_frame_dac: assert property (
		cs_rise && !enough && latch_hi
		|=> $stable(dac_reg)
	) else $error("short frame changed DAC registers");

	// Edge count baseline moves at every rise, accepted or not
	a_cnt_seen_track: assert property (
		cs_rise
		|=> cnt_seen_reg == $past(link.edge_cnt)
	) else $error("frame edge baseline not taken");

	a_cnt_seen_hold: assert property (
		!cs_rise
		|=> $stable(cnt_seen_reg)
	) else $error("frame edge baseline moved between rises");
endmodule : qdac_command_top

//--- verif/qdac_host_model.sv
// Host serial master model for the command link
`timescale 1ns/1ns
module qdac_host_model (
	output logic serial_clk,
	output logic chip_select_n,
	output logic serial_data_in,
	input wire logic serial_echo_out
);
	initial begin
		serial_clk = 1'b0;
		chip_select_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// Clock stands still between frames; echo sampled 1 ns after each rise
	task automatic send(input logic [31:0] w, input int n, output logic [31:0] e);
		e = '0;
		#1 chip_select_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			serial_data_in = w[i];
			#3 serial_clk = 1'b1;
			#1 e = {e[30:0], serial_echo_out};
			#2 serial_clk = 1'b0;
		end
		#3 chip_select_n = 1'b1;
		// Released line shows the inverse, not a stale bit
		serial_data_in = ~serial_data_in;
	endtask : send
endmodule : qdac_host_model

//--- verif/qdac_command_top_bench.sv
// Self-checking bench for the quad DAC command logic
`timescale 1ns/1ns
module qdac_command_top_bench;
	import qdac_pkg::*;
	typedef struct packed {qdac_bank_t i; qdac_bank_t d; logic m;} qdac_note_s;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic dac_latch_strobe_n = 1'b1;
	logic serial_clk, chip_select_n, serial_data_in, serial_echo_out;
	qdac_bank_t input_code, dac_code, in_m, dac_m;
	qdac_echo_e echo_mode;
	logic mode_m = 1'b1;
	logic [31:0] seed = 32'h8f8f5b19;
	logic [31:0] echo;
	qdac_note_s notes[$];
	qdac_note_s nt;
	int fail_count = 0;
	int total_checks = 0;
	event result_ev;
	always #4 ref_clk = ~ref_clk;
	qdac_host_model host (.serial_clk(serial_clk), .chip_select_n(chip_select_n),
		.serial_data_in(serial_data_in), .serial_echo_out(serial_echo_out));
	qdac_command_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .serial_clk(serial_clk),
		.chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
		.dac_latch_strobe_n(dac_latch_strobe_n), .serial_echo_out(serial_echo_out),
		.input_code(input_code), .dac_code(dac_code), .echo_mode(echo_mode));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xorshift
	task automatic wrap_up();
		$display("Checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic chk_bank(input string nm, input qdac_bank_t e, input qdac_bank_t g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_bank
	task automatic chk_bit(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit
	task automatic model(input logic [15:0] w, input logic lat_n);
		logic [1:0] sel;
		logic [1:0] ctl;
		sel = w[15:14];
		ctl = w[13:12];
		if (ctl == CTL_ALL_OR_NOP) begin
			if (!sel[0]) begin
				in_m = {NUM_CH{w[11:0]}};
				dac_m = in_m;
			end
		end else if (ctl == CTL_UPDATE) begin
			if (sel == SEL_MODE_RISE)
				mode_m = 1'b1;
			if (sel == SEL_MODE_FALL)
				mode_m = 1'b0;
			dac_m = in_m;
		end else begin
			in_m[sel] = w[11:0];
			if (ctl == CTL_LOAD_UPD)
				dac_m = in_m;
		end
		if (!lat_n)
			dac_m = in_m;
	endtask : model
	// Answer lands within 4 ref edges; 8 leaves margin
	task automatic note();
		notes.push_back('{in_m, dac_m, mode_m});
		repeat (8) @(posedge ref_clk);
		-> result_ev;
	endtask : note
	task automatic frame(input logic [31:0] w, input int n);
		host.send(w, n, echo);
		if (n >= 16)
			model(w[15:0], dac_latch_strobe_n);
		note();
	endtask : frame
	// Chained frame: upper word passes through, lower word is a no-op here
	task automatic echo_run(input logic [15:0] hi, input int lag);
		frame({hi, 16'h4000}, 32);
		for (int k = 0; k + lag < 32; k++)
			chk_bit("serial_echo_out", hi[k + lag - 16], echo[k]);
	endtask : echo_run
	always @(result_ev) begin
		nt = notes.pop_front();
		chk_bank("input_code", nt.i, input_code);
		chk_bank("dac_code", nt.d, dac_code);
		chk_bit("echo_mode", nt.m, echo_mode);
	end
	initial begin
		repeat (100000) @(posedge ref_clk);
		fail_count++;
		wrap_up();
	end
	initial begin
		in_m = '0;
		dac_m = '0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		note();
		chk_bit("serial_echo_out", 1'b0, serial_echo_out);
		// All 16 codes with both latch levels, then random words
		for (int c = 0; c < 56; c++) begin
			seed = xorshift(seed);
			@(posedge ref_clk) dac_latch_strobe_n <= (c < 32) ? c[4] : seed[20];
			repeat (4) @(posedge ref_clk);
			frame({16'h0, (c < 32) ? c[3:0] : seed[31:28], seed[11:0]}, 16);
		end
		@(posedge ref_clk) dac_latch_strobe_n <= 1'b1;
		frame(32'h1abc, 16);
		frame(32'h0555, 15);
		@(posedge ref_clk) dac_latch_strobe_n <= 1'b0;
		dac_m = in_m;
		note();
		@(posedge ref_clk) dac_latch_strobe_n <= 1'b1;
		frame(32'he000, 16);
		echo_run(16'h5a3c, 16);
		frame(32'ha000, 16);
		echo_run(16'hc3a5, 17);
		wrap_up();
	end
endmodule : qdac_command_top_bench
